/* design/sfr_frame_if.sv */
// Frame summary passed from the frame tracker to the control logic.
`timescale 1ns/1ps
interface sfr_frame_if;
    logic       selected;
    logic       frame_end;
    logic [5:0] edge_cnt;
    logic       all_ones;
    logic [7:0] cmd_byte;
    logic       conf_bit;

    modport tracker (
        output selected,
        output frame_end,
        output edge_cnt,
        output all_ones,
        output cmd_byte,
        output conf_bit
    );

    modport ctrl (
        input selected,
        input frame_end,
        input edge_cnt,
        input all_ones,
        input cmd_byte,
        input conf_bit
    );
endinterface

/* design/sfr_frame_track.sv */
// Counts serial clocks per select frame and captures line values.
`timescale 1ns/1ps
module sfr_frame_track (
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  sck,
    input  wire logic  cs_n,
    input  wire logic  dq0,
    input  wire logic  dq3,
    sfr_frame_if.tracker frm
);
    logic       sck_prev_ff, nxt_sck_prev;
    logic       cs_prev_ff,  nxt_cs_prev;
    logic       sel_ff,      nxt_sel;
    logic       end_ff,      nxt_end;
    logic [5:0] cnt_ff,      nxt_cnt;
    logic       ones_ff,     nxt_ones;
    logic [7:0] cmd_ff,      nxt_cmd;
    logic       conf_ff,     nxt_conf;
    logic       cs_fall;
    logic       sck_rise;
    logic [5:0] base_cnt;
    logic [5:0] cnt_inc;

    always_comb begin
        cs_fall     = !cs_n && cs_prev_ff;
        sck_rise    = sck && !sck_prev_ff && !cs_n;
        base_cnt    = cs_fall ? '0 : cnt_ff;
        cnt_inc     = (base_cnt == sfr_pkg::CNT_MAX) ? base_cnt
                                                     : 6'(base_cnt + 6'h01);
        nxt_sck_prev = sck;
        nxt_cs_prev  = cs_n;
        nxt_sel      = !cs_n;
        // A frame closes on the rising edge of the select line.
        nxt_end      = cs_n && !cs_prev_ff;
        nxt_cnt      = base_cnt;
        nxt_ones     = cs_fall | ones_ff;
        nxt_cmd      = cs_fall ? '0 : cmd_ff;
        nxt_conf     = cs_fall ? 1'b0 : conf_ff;
        if (sck_rise) begin
            nxt_cnt  = cnt_inc;
            // Both lines must stay high on every clock of a recovery frame.
            nxt_ones = nxt_ones & dq0 & dq3;
            if (base_cnt < sfr_pkg::CMD_LEN) begin
                nxt_cmd = {nxt_cmd[6:0], dq0};
            end
            // First dummy clock of an execute-in-place read.
            if (cnt_inc == sfr_pkg::CONF_EDGE) begin
                nxt_conf = dq0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_ff <= 1'b0;
            cs_prev_ff  <= 1'b1;
            sel_ff      <= 1'b0;
            end_ff      <= 1'b0;
            cnt_ff      <= '0;
            ones_ff     <= 1'b0;
            cmd_ff      <= '0;
            conf_ff     <= 1'b0;
        end else begin
            sck_prev_ff <= nxt_sck_prev;
            cs_prev_ff  <= nxt_cs_prev;
            sel_ff      <= nxt_sel;
            end_ff      <= nxt_end;
            cnt_ff      <= nxt_cnt;
            ones_ff     <= nxt_ones;
            cmd_ff      <= nxt_cmd;
            conf_ff     <= nxt_conf;
        end
    end

    assign frm.selected  = sel_ff;
    assign frm.frame_end = end_ff;
    assign frm.edge_cnt  = cnt_ff;
    assign frm.all_ones  = ones_ff;
    assign frm.cmd_byte  = cmd_ff;
    assign frm.conf_bit  = conf_ff;
endmodule

/* design/sfr_pkg.sv */
// Shared constants and types of the power-mode and interface-rescue block.
package sfr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Power modes and serial protocols.
    typedef enum logic [1:0] {
        SFR_ACTIVE  = 2'b00,
        SFR_STANDBY = 2'b01,
        SFR_DEEP    = 2'b10
    } sfr_mode_e;

    typedef enum logic [1:0] {
        SFR_EXT  = 2'b00,
        SFR_DUAL = 2'b01,
        SFR_QUAD = 2'b10
    } sfr_proto_e;

    ////////////////////////////////////////////////////////////////////////
    // Frame lengths in serial clocks.
    localparam int         CNT_W      = 6;
    localparam logic [5:0] CNT_MAX    = 6'h3F;
    localparam logic [5:0] CMD_LEN    = 6'h08;
    localparam logic [5:0] PLR_LEN    = 6'h08;
    localparam logic [5:0] RESCUE_LEN = 6'h10;
    localparam logic [5:0] CONF_EDGE  = 6'h19;
    localparam logic [5:0] STEP_LEN0  = 6'h07;
    localparam logic [5:0] STEP_LEN1  = 6'h09;
    localparam logic [5:0] STEP_LEN2  = 6'h0D;
    localparam logic [5:0] STEP_LEN3  = 6'h11;
    localparam logic [5:0] STEP_LEN4  = 6'h19;
    localparam logic [5:0] STEP_LEN5  = 6'h21;
    localparam logic [2:0] STEP_DONE  = 3'h6;

    ////////////////////////////////////////////////////////////////////////
    // Delivery values and configuration field positions.
    localparam logic [15:0] NV_DELIVERY     = 16'hFFFF;
    localparam logic [7:0]  STATUS_DELIVERY = 8'h00;
    localparam int          NV_XIP_BIT      = 9;
    localparam int          NV_DUAL_BIT     = 6;
    localparam int          NV_QUAD_BIT     = 7;
    localparam int          SYNC_STAGES     = 2;

endpackage

/* design/sfr_power_rescue.sv */
// Power-mode control and serial interface rescue of a serial flash.
//
// Overview of operation
// - Selected device is in active power mode.
// - Deselected stays active until operations finish.
// - Enter command puts device in deep power-down.
// - Release command leaves deep power-down.
// - Power-loss recovery forces single-line, no execute-in-place.
// - Rescue restores interface only, operations continue.
// - Step one: six all-ones frames, 7 to 33.
// - Power-loss second step: eight all-ones clocks.
// - Rescue second step: sixteen all-ones clocks.
// - After either sequence, single-line commands accepted.
// - Delivery: status zero, configuration erased.
// - Confirmation bit one ends execute-in-place.
// - Recovery frames end execute-in-place, keep operations.
`timescale 1ns/1ps
module sfr_power_rescue #(
    parameter logic [7:0] DEEP_ENTER_OP = 8'hE1,
    parameter logic [7:0] DEEP_EXIT_OP  = 8'hE2
) (
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    input  wire logic        SPI_CLK,
    input  wire logic        SPI_SEL_N,
    input  wire logic        DATA_LINE_ZERO,
    input  wire logic        HOLD_DATA_LINE_THREE,
    input  wire logic        OP_BUSY,
    input  wire logic [15:0] NV_CONFIG,
    output logic      [1:0]  POWER_MODE,
    output logic      [1:0]  PROTOCOL,
    output logic             XIP_ACTIVE,
    output logic             XIP_LOCKED,
    output logic      [2:0]  SEQ_STEP,
    output logic      [7:0]  STATUS
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and frame tracking.
    logic [3:0] pins_sync;

    // Reset values match the idle pin levels, so that releasing reset
    // never shows a false select or a false clock edge.
    sfr_sync #(
        .W       (4),
        .RST_VAL (4'h4)
    ) u_sync (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .din   ({SPI_CLK, SPI_SEL_N, DATA_LINE_ZERO, HOLD_DATA_LINE_THREE}),
        .dout  (pins_sync)
    );

    sfr_frame_if frm ();

    sfr_frame_track u_track (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .sck   (pins_sync[3]),
        .cs_n  (pins_sync[2]),
        .dq0   (pins_sync[1]),
        .dq3   (pins_sync[0]),
        .frm   (frm.tracker)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control state.
    sfr_pkg::sfr_mode_e  mode_ff,   nxt_mode;
    sfr_pkg::sfr_proto_e proto_ff,  nxt_proto;
    logic                xip_ff,    nxt_xip;
    logic                lock_ff,   nxt_lock;
    logic [2:0]          step_ff,   nxt_step;
    logic [15:0]         nv_ff,     nxt_nv;
    logic                init_ff,   nxt_init;
    logic [7:0]          status_ff, nxt_status;
    logic                full_cmd;
    logic                step_hit;
    logic                restart;
    logic                plr_done;
    logic                rescue_done;
    logic                conf_exit;

    function automatic logic [5:0] step_len(input logic [2:0] idx);
        case (idx)
            3'h0:    step_len = sfr_pkg::STEP_LEN0;
            3'h1:    step_len = sfr_pkg::STEP_LEN1;
            3'h2:    step_len = sfr_pkg::STEP_LEN2;
            3'h3:    step_len = sfr_pkg::STEP_LEN3;
            3'h4:    step_len = sfr_pkg::STEP_LEN4;
            3'h5:    step_len = sfr_pkg::STEP_LEN5;
            default: step_len = sfr_pkg::CNT_MAX;
        endcase
    endfunction

    function automatic sfr_pkg::sfr_proto_e nv_proto(input logic [15:0] nv);
        if (!nv[sfr_pkg::NV_QUAD_BIT]) begin
            nv_proto = sfr_pkg::SFR_QUAD;
        end else if (!nv[sfr_pkg::NV_DUAL_BIT]) begin
            nv_proto = sfr_pkg::SFR_DUAL;
        end else begin
            nv_proto = sfr_pkg::SFR_EXT;
        end
    endfunction

    always_comb begin
        // Only a frame of exactly one opcode counts as a command.
        full_cmd    = frm.frame_end && !xip_ff
                      && (frm.edge_cnt == sfr_pkg::CMD_LEN);
        step_hit    = frm.frame_end && frm.all_ones
                      && (mode_ff != sfr_pkg::SFR_DEEP)
                      && (step_ff < sfr_pkg::STEP_DONE)
                      && (frm.edge_cnt == step_len(step_ff));
        restart     = frm.frame_end && frm.all_ones
                      && (mode_ff != sfr_pkg::SFR_DEEP)
                      && (frm.edge_cnt == sfr_pkg::STEP_LEN0);
        plr_done    = frm.frame_end && frm.all_ones
                      && (mode_ff != sfr_pkg::SFR_DEEP)
                      && (step_ff == sfr_pkg::STEP_DONE)
                      && (frm.edge_cnt == sfr_pkg::PLR_LEN);
        rescue_done = frm.frame_end && frm.all_ones
                      && (mode_ff != sfr_pkg::SFR_DEEP)
                      && (step_ff == sfr_pkg::STEP_DONE)
                      && (frm.edge_cnt == sfr_pkg::RESCUE_LEN);
        conf_exit   = frm.frame_end && xip_ff && frm.conf_bit
                      && (frm.edge_cnt >= sfr_pkg::CONF_EDGE);

        nxt_mode   = mode_ff;
        nxt_proto  = proto_ff;
        nxt_xip    = xip_ff;
        nxt_lock   = lock_ff;
        nxt_step   = step_ff;
        nxt_nv     = nv_ff;
        nxt_init   = 1'b1;
        // Status shows only the write-in-progress bit of this block.
        nxt_status = sfr_pkg::STATUS_DELIVERY | 8'(OP_BUSY);

        unique case (mode_ff)
            sfr_pkg::SFR_DEEP: begin
                if (full_cmd && frm.cmd_byte == DEEP_EXIT_OP) begin
                    nxt_mode = sfr_pkg::SFR_ACTIVE;
                end
            end
            sfr_pkg::SFR_ACTIVE, sfr_pkg::SFR_STANDBY: begin
                if (full_cmd && frm.cmd_byte == DEEP_ENTER_OP) begin
                    nxt_mode = sfr_pkg::SFR_DEEP;
                end else if (frm.selected || OP_BUSY) begin
                    nxt_mode = sfr_pkg::SFR_ACTIVE;
                end else begin
                    nxt_mode = sfr_pkg::SFR_STANDBY;
                end
            end
            default: nxt_mode = sfr_pkg::SFR_STANDBY;
        endcase

        // Outside deep power-down, any frame other than the expected one restarts the sequence.
        if (frm.frame_end && mode_ff != sfr_pkg::SFR_DEEP) begin
            if (step_hit) begin
                nxt_step = 3'(step_ff + 3'h1);
            end else if (restart) begin
                nxt_step = 3'h1;
            end else begin
                nxt_step = 3'h0;
            end
        end

        if (conf_exit || step_hit || restart) begin
            nxt_xip = 1'b0;
        end
        if (plr_done) begin
            nxt_proto = sfr_pkg::SFR_EXT;
            nxt_xip   = 1'b0;
            nxt_lock  = 1'b1;
        end
        if (rescue_done) begin
            // Interface only; busy operations are left running.
            nxt_nv    = NV_CONFIG;
            nxt_proto = sfr_pkg::SFR_EXT;
            nxt_xip   = 1'b0;
        end

        // Configuration is taken once, in the first cycle after reset.
        if (!init_ff) begin
            nxt_nv    = NV_CONFIG;
            nxt_proto = nv_proto(NV_CONFIG);
            nxt_xip   = !NV_CONFIG[sfr_pkg::NV_XIP_BIT];
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_ff   <= sfr_pkg::SFR_STANDBY;
            proto_ff  <= sfr_pkg::SFR_EXT;
            xip_ff    <= 1'b0;
            lock_ff   <= 1'b0;
            step_ff   <= 3'h0;
            nv_ff     <= sfr_pkg::NV_DELIVERY;
            init_ff   <= 1'b0;
            status_ff <= sfr_pkg::STATUS_DELIVERY;
        end else begin
            mode_ff   <= nxt_mode;
            proto_ff  <= nxt_proto;
            xip_ff    <= nxt_xip;
            lock_ff   <= nxt_lock;
            step_ff   <= nxt_step;
            nv_ff     <= nxt_nv;
            init_ff   <= nxt_init;
            status_ff <= nxt_status;
        end
    end

    assign POWER_MODE = mode_ff;
    assign PROTOCOL   = proto_ff;
    assign XIP_ACTIVE = xip_ff;
    assign XIP_LOCKED = lock_ff;
    assign SEQ_STEP   = step_ff;
    assign STATUS     = status_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);

    a_selected_active: assert property (
        (mode_ff != sfr_pkg::SFR_DEEP) && frm.selected && !full_cmd
        |=> mode_ff == sfr_pkg::SFR_ACTIVE)
        else $error("selected device not active");

    a_busy_active: assert property (
        (mode_ff != sfr_pkg::SFR_DEEP) && OP_BUSY && !full_cmd
        |=> mode_ff == sfr_pkg::SFR_ACTIVE)
        else $error("busy device left active mode");

    a_standby_entry: assert property (
        (mode_ff == sfr_pkg::SFR_ACTIVE) && !frm.selected && !OP_BUSY
        && !frm.frame_end
        |=> mode_ff == sfr_pkg::SFR_STANDBY)
        else $error("idle deselected device not in standby");

    a_deep_entry: assert property (
        full_cmd && frm.cmd_byte == DEEP_ENTER_OP
        && mode_ff != sfr_pkg::SFR_DEEP
        |=> mode_ff == sfr_pkg::SFR_DEEP ##1 mode_ff == sfr_pkg::SFR_DEEP)
        else $error("enter command did not reach deep power-down");

    a_deep_exit: assert property (
        mode_ff == sfr_pkg::SFR_DEEP && full_cmd
        && frm.cmd_byte == DEEP_EXIT_OP
        |=> mode_ff == sfr_pkg::SFR_ACTIVE)
        else $error("release command did not leave deep power-down");

    a_deep_holds: assert property (
        mode_ff == sfr_pkg::SFR_DEEP && frm.frame_end
        && frm.edge_cnt != sfr_pkg::CMD_LEN
        |=> mode_ff == sfr_pkg::SFR_DEEP)
        else $error("partial frame changed deep power-down");

    a_plr_result: assert property (
        plr_done |=> proto_ff == sfr_pkg::SFR_EXT && !xip_ff && lock_ff)
        else $error("power-loss recovery did not force single line");

    a_lock_xip: assert property (
        lock_ff |-> !xip_ff && ($past(lock_ff) || $past(plr_done)))
        else $error("execute-in-place active while locked");

    a_rescue_proto: assert property (
        rescue_done |=> proto_ff == sfr_pkg::SFR_EXT && step_ff == 3'h0)
        else $error("rescue did not return to single line");

    a_step_advance: assert property (
        step_hit |=> step_ff == $past(step_ff) + 3'h1)
        else $error("step frame did not advance the sequence");

    a_step_xip_off: assert property (
        step_hit || restart |=> !xip_ff)
        else $error("recovery frame left execute-in-place on");

    a_conf_exit: assert property (
        conf_exit |=> !xip_ff)
        else $error("confirmation one did not end execute-in-place");

    a_short_frame: assert property (
        frm.frame_end && !full_cmd && !step_hit && !restart && !plr_done
        && !rescue_done && !conf_exit
        |=> proto_ff == $past(proto_ff) && xip_ff == $past(xip_ff)
            && lock_ff == $past(lock_ff))
        else $error("unmatched frame changed the interface state");

    a_rescue_keeps: assert property (
        rescue_done |=> lock_ff == $past(lock_ff)
                        && nv_ff == $past(NV_CONFIG))
        else $error("rescue touched more than the interface");

    a_deep_no_step: assert property (
        mode_ff == sfr_pkg::SFR_DEEP && frm.frame_end
        |=> step_ff == $past(step_ff))
        else $error("frame in deep power-down moved the sequence");

    a_xip_no_cmd: assert property (
        xip_ff && mode_ff != sfr_pkg::SFR_DEEP && frm.frame_end
        && frm.edge_cnt == sfr_pkg::CMD_LEN
        |=> mode_ff != sfr_pkg::SFR_DEEP)
        else $error("opcode decoded during execute-in-place");

    c_deep_cycle: cover property (
        mode_ff == sfr_pkg::SFR_DEEP ##[1:1000]
        mode_ff == sfr_pkg::SFR_ACTIVE);
    c_plr_done: cover property (plr_done);
    c_rescue_done: cover property (rescue_done);
    c_conf_exit: cover property (conf_exit);
endmodule

/* design/sfr_sync.sv */
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module sfr_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
        end else begin
            stage1_ff <= din;
            stage2_ff <= stage1_ff;
        end
    end

    assign dout = stage2_ff;
endmodule

/* verif/sfr_host_model.sv */
// Behavioural host controller that frames serial traffic toward the block.
`timescale 1ns/1ps
module sfr_host_model #(
    parameter int HALF = 10
) (
    input  wire logic mclk,
    output logic      spi_clk,
    output logic      sel_n,
    output logic      dq0,
    output logic      dq3,
    output logic      frame_end
);
    logic dq0_ff;
    logic idle_ff;

    initial begin
        spi_clk   = 1'b0;
        sel_n     = 1'b1;
        dq0_ff    = 1'b0;
        idle_ff   = 1'b0;
        frame_end = 1'b0;
    end

    // Released lines toggle every cycle so a stale level is never trusted.
    always @(posedge mclk) begin
        idle_ff <= ~idle_ff;
    end

    assign dq0 = sel_n ? idle_ff : dq0_ff;
    assign dq3 = sel_n ? ~idle_ff : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // One select frame of n clocks; data changes with the falling clock.
    task automatic send(input int n, input logic [63:0] bits, input int gap);
        int g;
        g = (gap < 7) ? 7 : gap;
        repeat (g) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            sel_n  <= 1'b0;
            dq0_ff <= bits[63-i];
            repeat (HALF) @(posedge mclk);
            spi_clk <= 1'b1;
            repeat (HALF) @(posedge mclk);
            spi_clk <= 1'b0;
        end
        repeat (HALF) @(posedge mclk);
        sel_n     <= 1'b1;
        frame_end <= 1'b1;
        @(posedge mclk);
        frame_end <= 1'b0;
    endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench of the power-mode and interface-rescue block.
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] ENTER_OP = 8'hE1;
    localparam logic [7:0] EXIT_OP  = 8'hE2;
    localparam logic [1:0] ACT      = sfr_pkg::SFR_ACTIVE;
    localparam logic [1:0] SBY      = sfr_pkg::SFR_STANDBY;
    localparam logic [1:0] DPD      = sfr_pkg::SFR_DEEP;
    localparam logic [1:0] EXT      = sfr_pkg::SFR_EXT;
    localparam logic [1:0] DUA      = sfr_pkg::SFR_DUAL;
    localparam logic [1:0] QUA      = sfr_pkg::SFR_QUAD;

    logic        mclk;
    logic        reset_n;
    logic        op_busy;
    logic [15:0] nv_config;
    logic        spi_clk;
    logic        spi_sel_n;
    logic        dq0;
    logic        dq3;
    logic        frame_end;
    logic        probe;
    logic [1:0]  power_mode;
    logic [1:0]  protocol;
    logic        xip_active;
    logic        xip_locked;
    logic [2:0]  seq_step;
    logic [7:0]  status;
    logic [63:0] bits;
    logic [16:0] exp_q [$];
    int          lens [6];
    int          err_count;
    int          n_checks;

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    sfr_power_rescue #(
        .DEEP_ENTER_OP (ENTER_OP),
        .DEEP_EXIT_OP  (EXIT_OP)
    ) i_sfr_power_rescue (
        .MCLK                 (mclk),
        .RESET_N              (reset_n),
        .SPI_CLK              (spi_clk),
        .SPI_SEL_N            (spi_sel_n),
        .DATA_LINE_ZERO       (dq0),
        .HOLD_DATA_LINE_THREE (dq3),
        .OP_BUSY              (op_busy),
        .NV_CONFIG            (nv_config),
        .POWER_MODE           (power_mode),
        .PROTOCOL             (protocol),
        .XIP_ACTIVE           (xip_active),
        .XIP_LOCKED           (xip_locked),
        .SEQ_STEP             (seq_step),
        .STATUS               (status)
    );

    sfr_host_model i_sfr_host_model (
        .mclk      (mclk),
        .spi_clk   (spi_clk),
        .sel_n     (spi_sel_n),
        .dq0       (dq0),
        .dq3       (dq3),
        .frame_end (frame_end)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers.
    function automatic int gap();
        return 7 + int'($urandom_range(0, 40));
    endfunction

    task automatic note_exp(input logic [1:0] m, input logic [1:0] p,
                            input logic x, input logic l,
                            input logic [2:0] s, input logic b);
        exp_q.push_back({m, p, x, l, s, 7'h00, b});
    endtask

    task automatic tx(input int n, input logic [63:0] b);
        i_sfr_host_model.send(n, b, gap());
        // Hold the next stimulus until the monitor has compared this frame.
        repeat (8) @(posedge mclk);
    endtask

    task automatic probe_now();
        repeat (8) @(posedge mclk);
        probe <= 1'b1;
        @(posedge mclk);
        probe <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask

    task automatic reset_dut(input logic [15:0] nv);
        @(posedge mclk);
        reset_n   <= 1'b0;
        nv_config <= nv;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
    endtask

    task automatic run_steps(input int n, input logic [1:0] m,
                             input logic [1:0] p);
        for (int k = 0; k < n; k++) begin
            note_exp(m, p, 1'b0, 1'b0, 3'(k + 1), op_busy);
            tx(lens[k], '1);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Outputs settle four cycles after the pin edge; compare after six.
    initial begin
        logic [16:0] got;
        logic [16:0] want;
        forever begin
            @(posedge mclk);
            if (frame_end === 1'b1 || probe === 1'b1) begin
                repeat (6) @(posedge mclk);
                #1;
                got = {power_mode, protocol, xip_active, xip_locked,
                       seq_step, status};
                n_checks++;
                if (exp_q.size() == 0) begin
                    err_count++;
                    $display("ERROR %0t: result without note", $time);
                end else begin
                    want = exp_q.pop_front();
                    if (got !== want) begin
                        err_count++;
                        $display("ERROR %0t: got %h want %h", $time, got,
                                 want);
                    end
                end
            end
        end
    end

    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        $display("ERROR %0t: run did not finish", $time);
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(84209));
        lens      = '{7, 9, 13, 17, 25, 33};
        err_count = 0;
        n_checks  = 0;
        probe     = 1'b0;
        reset_n   = 1'b0;
        op_busy   = 1'b0;
        nv_config = 16'hFF7F;
        reset_dut(16'hFF7F);
        note_exp(SBY, QUA, 1'b0, 1'b0, 3'h0, 1'b0);
        probe_now();
        reset_dut(16'hFFBF);
        note_exp(SBY, DUA, 1'b0, 1'b0, 3'h0, 1'b0);
        probe_now();
        reset_dut(16'hFFFF);
        note_exp(SBY, EXT, 1'b0, 1'b0, 3'h0, 1'b0);
        probe_now();
        $display("test configuration done");

        fork
            tx(5, {$urandom, $urandom});
            begin
                repeat (60) @(posedge mclk);
                note_exp(ACT, EXT, 1'b0, 1'b0, 3'h0, 1'b0);
                probe_now();
                note_exp(SBY, EXT, 1'b0, 1'b0, 3'h0, 1'b0);
            end
        join
        op_busy <= 1'b1;
        note_exp(ACT, EXT, 1'b0, 1'b0, 3'h0, 1'b1);
        tx(5, '1);
        op_busy <= 1'b0;
        note_exp(SBY, EXT, 1'b0, 1'b0, 3'h0, 1'b0);
        probe_now();
        $display("test power modes done");

        note_exp(DPD, EXT, 1'b0, 1'b0, 3'h0, 1'b0);
        tx(8, {ENTER_OP, 56'h0});
        note_exp(DPD, EXT, 1'b0, 1'b0, 3'h0, 1'b0);
        tx(7, '1);
        note_exp(SBY, EXT, 1'b0, 1'b0, 3'h0, 1'b0);
        tx(8, {EXIT_OP, 56'h0});
        run_steps(1, SBY, EXT);
        $display("test deep power-down done");

        op_busy <= 1'b1;
        reset_dut(16'hFD7F);
        note_exp(ACT, QUA, 1'b1, 1'b0, 3'h0, 1'b1);
        probe_now();
        run_steps(6, ACT, QUA);
        note_exp(ACT, EXT, 1'b0, 1'b1, 3'h0, 1'b1);
        tx(8, '1);
        $display("test power loss recovery done");

        reset_dut(16'hFFBF);
        note_exp(ACT, DUA, 1'b0, 1'b0, 3'h0, 1'b1);
        probe_now();
        run_steps(2, ACT, DUA);
        note_exp(ACT, DUA, 1'b0, 1'b0, 3'h0, 1'b1);
        tx(9, ~(64'h1 << 59));
        run_steps(6, ACT, DUA);
        note_exp(ACT, EXT, 1'b0, 1'b0, 3'h0, 1'b1);
        tx(16, '1);
        op_busy <= 1'b0;
        note_exp(DPD, EXT, 1'b0, 1'b0, 3'h0, 1'b0);
        tx(8, {ENTER_OP, 56'h0});
        $display("test interface rescue done");

        reset_dut(16'hFDFF);
        note_exp(SBY, EXT, 1'b1, 1'b0, 3'h0, 1'b0);
        probe_now();
        note_exp(SBY, EXT, 1'b1, 1'b0, 3'h0, 1'b0);
        tx(8, {ENTER_OP, 56'h0});
        bits     = {$urandom, $urandom};
        bits[39] = 1'b0;
        note_exp(SBY, EXT, 1'b1, 1'b0, 3'h0, 1'b0);
        tx(30, bits);
        bits[39] = 1'b1;
        note_exp(SBY, EXT, 1'b0, 1'b0, 3'h0, 1'b0);
        tx(30, bits);
        $display("test confirmation bit done");

        repeat (20) @(posedge mclk);
        if (exp_q.size() != 0) begin
            err_count++;
            $display("ERROR %0t: results missing", $time);
        end
        tally_and_finish();
    end
endmodule
